/* File: snr_pkg.sv */
// package of constants for the spi nvram read, sleep and ident block
package snr_pkg;
	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] SNR_OP_FAST_READ  = 8'h0b;
	localparam logic [7:0] SNR_OP_SLEEP      = 8'hb9;
	localparam logic [7:0] SNR_OP_READ_IDENT = 8'h9f;

	// ----------------------------------------------------------------
	// geometry and counts
	// ----------------------------------------------------------------
	localparam int         SNR_ADDR_W     = 15;
	localparam int         SNR_IDENT_LEN  = 9;
	localparam logic [2:0] SNR_BIT_LAST   = 3'h7;
	localparam logic [1:0] SNR_HDR_ADDR_LO = 2'h1;
	localparam logic [1:0] SNR_HDR_DUMMY  = 2'h2;
	localparam logic [3:0] SNR_IDENT_LAST = 4'h8;
	localparam logic [3:0] SNR_ID_MFR_LAST = 4'h6;

	// ----------------------------------------------------------------
	// identity: every value here but the reserved field is arbitrary
	// ----------------------------------------------------------------
	localparam logic [7:0] SNR_ID_CONT   = 8'h5a;  // arbitrary
	localparam logic [7:0] SNR_ID_MFR    = 8'h3c;  // arbitrary
	localparam logic [2:0] SNR_ID_FAMILY = 3'h1;   // arbitrary
	localparam logic [4:0] SNR_ID_DENS   = 5'h02;  // arbitrary
	localparam logic [1:0] SNR_ID_SUB    = 2'h1;   // arbitrary
	localparam logic [2:0] SNR_ID_REV    = 3'h1;   // arbitrary
	localparam logic [2:0] SNR_ID_RSVD   = 3'h0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SNR_CLK_NS      = 4;
	localparam int SNR_WAKE_REC_NS = 400;  // wake_recovery_time, plain default
	localparam int SNR_WAKE_CYC    = SNR_WAKE_REC_NS / SNR_CLK_NS;

	// ----------------------------------------------------------------
	// command states, gray along opcode -> header -> data
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SNR_ST_OPCODE = 3'h0,
		SNR_ST_HEADER = 3'h1,
		SNR_ST_DATA   = 3'h3,
		SNR_ST_IDENT  = 3'h2,
		SNR_ST_IGNORE = 3'h6,
		SNR_ST_SLEEP  = 3'h7,
		SNR_ST_WAKE   = 3'h5
	} snr_state_t;
endpackage

/* File: snr_spi_nvram.sv */
// spi slave logic: fast read, hold, sleep/wake and ident readout
// How it works
// - opcode 0bh first byte is fast read
// - two address bytes then one dummy byte
// - dummy byte is eight silent clocks
// - data bytes shift out msb first continuously
// - address increments per byte, wraps 7fffh
// - serial input ignored while data drives out
// - chip select rise ends read, output released
// - hold low while sck low freezes operation
// - hold high while sck low resumes operation
// - opcode b9h then select rise enters sleep
// - asleep: ignore sck, si; output released
// - select fall wakes after recovery time
// - opcode 9fh returns manufacturer then product
// - ident nine bytes: six continuation, one id
// - product bytes: family, density, sub, rev, rsvd
// - address msb ignored, fifteen bits used
module snr_spi_nvram
	import snr_pkg::*;
#(
	parameter int ADDR_W   = SNR_ADDR_W,
	parameter int WAKE_CYC = SNR_WAKE_CYC
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// spi pins
	input  wire logic              cs_n_i,
	input  wire logic              sck_i,
	input  wire logic              si_i,
	input  wire logic              hold_n_i,
	output logic                   so_o,
	output logic                   so_oe_o,
	// memory array read port
	output logic [ADDR_W-1:0]      mem_addr_o,
	input  wire logic [7:0]        mem_data_i,
	// status
	output logic                   asleep_o
);
	localparam int WAKE_W = $clog2(WAKE_CYC + 1);
	localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYC - 1);

	// ----------------------------------------------------------------
	// ident byte table
	// ----------------------------------------------------------------
	function automatic logic [7:0] ident_byte(input logic [3:0] idx);
		logic [15:0] prod;
		prod = {SNR_ID_FAMILY, SNR_ID_DENS, SNR_ID_SUB, SNR_ID_REV, SNR_ID_RSVD};
		if (idx < SNR_ID_MFR_LAST) begin
			ident_byte = SNR_ID_CONT;
		end else if (idx == SNR_ID_MFR_LAST) begin
			ident_byte = SNR_ID_MFR;
		end else if (idx == SNR_IDENT_LAST) begin
			ident_byte = prod[7:0];
		end else begin
			ident_byte = prod[15:8];
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic       cs_n_q;
	logic       sck_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_q <= 4'hf;
			sync2_q <= 4'hf;
			cs_n_q  <= 1'b1;
			sck_q   <= 1'b0;
		end else begin
			sync1_q <= {cs_n_i, sck_i, si_i, hold_n_i};
			sync2_q <= sync1_q;
			cs_n_q  <= sync2_q[3];
			sck_q   <= sync2_q[2];
		end
	end
	logic cs_n_s, sck_s, si_s, hold_n_s;
	assign {cs_n_s, sck_s, si_s, hold_n_s} = sync2_q;

	// ----------------------------------------------------------------
	// hold latch: changes only while sck is low
	// ----------------------------------------------------------------
	logic held_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			held_q <= 1'b0;
		end else if (!sck_s) begin
			held_q <= !hold_n_s;
		end
	end

	// edges; sck edges frozen while held so all progress is kept
	logic cs_rise, cs_fall, sck_rise, sck_fall;
	assign cs_rise  = cs_n_s && !cs_n_q;
	assign cs_fall  = !cs_n_s && cs_n_q;
	assign sck_rise = sck_s && !sck_q && !cs_n_s && !held_q;
	assign sck_fall = !sck_s && sck_q && !cs_n_s && !held_q;

	// ----------------------------------------------------------------
	// command state
	// ----------------------------------------------------------------
	snr_state_t        state_q;
	logic [2:0]        bit_q;
	logic [1:0]        hdr_q;
	logic [7:0]        shin_q;
	logic [7:0]        shout_q;
	logic [3:0]        id_q;
	logic [ADDR_W-1:0] addr_q;
	logic              sleep_arm_q;
	logic [WAKE_W-1:0] wake_q;
	logic              byte_done;
	logic [7:0]        in_byte;
	assign byte_done = sck_rise && (bit_q == SNR_BIT_LAST);
	assign in_byte   = {shin_q[6:0], si_s};

	// input shifter and bit count, sampled on rising sck
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bit_q  <= 3'h0;
			shin_q <= 8'h00;
		end else if (cs_n_s) begin
			bit_q <= 3'h0;
		end else if (sck_rise) begin
			bit_q  <= bit_q + 3'h1;
			shin_q <= in_byte;  // unused once data flows
		end
	end

	// state machine
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q     <= SNR_ST_OPCODE;
			hdr_q       <= 2'h0;
			addr_q      <= '0;
			id_q        <= 4'h0;
			sleep_arm_q <= 1'b0;
			wake_q      <= '0;
		end else begin
			case (state_q)
				SNR_ST_SLEEP: begin
					if (cs_fall) begin
						state_q <= SNR_ST_WAKE;
						wake_q  <= '0;
					end
				end
				SNR_ST_WAKE: begin
					wake_q <= wake_q + WAKE_W'(1);
					if (wake_q == WAKE_LAST) begin
						state_q <= cs_n_s ? SNR_ST_OPCODE : SNR_ST_IGNORE;
					end
				end
				default: begin
					if (cs_n_s) begin
						if (cs_rise && sleep_arm_q) begin
							state_q <= SNR_ST_SLEEP;
						end else begin
							state_q <= SNR_ST_OPCODE;
						end
						sleep_arm_q <= 1'b0;
						hdr_q       <= 2'h0;
					end else if (byte_done) begin
						case (state_q)
							SNR_ST_OPCODE: begin
								if (in_byte == SNR_OP_FAST_READ) begin
									state_q <= SNR_ST_HEADER;
								end else if (in_byte == SNR_OP_READ_IDENT) begin
									state_q <= SNR_ST_IDENT;
									id_q    <= 4'h0;
								end else if (in_byte == SNR_OP_SLEEP) begin
									sleep_arm_q <= 1'b1;
									state_q     <= SNR_ST_IGNORE;
								end else begin
									state_q <= SNR_ST_IGNORE;
								end
							end
							SNR_ST_HEADER: begin
								hdr_q <= hdr_q + 2'h1;
								if (hdr_q == 2'h0) begin
									addr_q[ADDR_W-1:8] <= in_byte[ADDR_W-9:0];
								end else if (hdr_q == SNR_HDR_ADDR_LO) begin
									addr_q[7:0] <= in_byte;
								end else if (hdr_q == SNR_HDR_DUMMY) begin
									state_q <= SNR_ST_DATA;
								end
							end
							SNR_ST_DATA: begin
								addr_q <= addr_q + ADDR_W'(1);
							end
							SNR_ST_IDENT: begin
								if (id_q != SNR_IDENT_LAST) begin
									id_q <= id_q + 4'h1;
								end
							end
							SNR_ST_IGNORE: begin
								sleep_arm_q <= 1'b0;  // extra bytes cancel sleep
							end
							default: state_q <= SNR_ST_IGNORE;
						endcase
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// output shifter: loads a byte at bit 0, shifts after falling sck
	// ----------------------------------------------------------------
	logic       driving;
	logic [7:0] load_byte;
	assign driving   = (state_q == SNR_ST_DATA) || (state_q == SNR_ST_IDENT);
	// byte to start shifting: array data or the ident table entry
	assign load_byte = (state_q == SNR_ST_DATA) ? mem_data_i : ident_byte(id_q);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shout_q <= 8'h00;
			so_o    <= 1'b0;
			so_oe_o <= 1'b0;
		end else begin
			if (sck_fall && driving) begin
				if (bit_q == 3'h0) begin
					shout_q <= {load_byte[6:0], 1'b0};
					so_o    <= load_byte[7];
				end else begin
					shout_q <= {shout_q[6:0], 1'b0};
					so_o    <= shout_q[7];
				end
			end
			so_oe_o <= driving && !cs_n_s && !held_q;
		end
	end

	// registered outputs
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_addr_o <= '0;
			asleep_o   <= 1'b0;
		end else begin
			mem_addr_o <= addr_q;
			asleep_o   <= (state_q == SNR_ST_SLEEP) || (state_q == SNR_ST_WAKE);
		end
	end
endmodule

/* File: snr_spi_nvram_asserts.sv */
// checker of the nvram block's behaviour at its ports
module snr_spi_nvram_asserts
	import snr_pkg::*;
#(
	parameter int ADDR_W   = SNR_ADDR_W,
	parameter int WAKE_CYC = SNR_WAKE_CYC
) (
	// watched ports
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              cs_n_i,
	input wire logic              sck_i,
	input wire logic              hold_n_i,
	input wire logic              so_o,
	input wire logic              so_oe_o,
	input wire logic [ADDR_W-1:0] mem_addr_o,
	input wire logic              asleep_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// margin covers the select synchroniser ahead of the wake count
	localparam int WMAX = WAKE_CYC + 8;
	// last cycle still asleep: two sync flops, edge detect, count, output register
	localparam int WMIN = WAKE_CYC + 3;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// output settled well into a high sck phase
	sequence sck_high_s;
		sck_i[*4] ##1 (sck_i && so_oe_o && $past(so_oe_o));
	endsequence
	sequence wake_s;
		asleep_o && $fell(cs_n_i);
	endsequence
	oe_idle_a: assert property (cs_n_i[*6] |-> !so_oe_o) else $error("so driven while deselected");
	sleep_quiet_a: assert property (asleep_o |-> !so_oe_o) else $error("so driven while asleep");
	hold_off_a: assert property ((!hold_n_i)[*8] |-> !so_oe_o) else $error("so driven during hold");
	so_stable_a: assert property (sck_high_s |-> $stable(so_o)) else $error("so moved while sck high");
	addr_wrap_a: assert property ($changed(mem_addr_o) && $past(mem_addr_o) == '1 |-> mem_addr_o == '0)
		else $error("address did not wrap to zero");
	sleep_enter_a: assert property ($rose(asleep_o) |-> cs_n_i) else $error("sleep entered while selected");
	wake_min_a: assert property (wake_s |-> ##WMIN asleep_o) else $error("wake recovery too short");
	wake_max_a: assert property (wake_s |-> ##[1:WMAX] !asleep_o) else $error("wake recovery too long");
endmodule

/* File: snr_spi_master.sv */
// spi bus master model, mode 0 or mode 3, sck 80 ns
module snr_spi_master (
	// clock and device output
	input  wire logic clk_i,
	input  wire logic so_i,
	input  wire logic so_oe_i,
	// pins to the device
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      si_o,
	output logic      hold_n_o,
	// resolved line and activity flag
	output logic      so_w_o,
	output logic      oe_seen_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_q = 1'b0;
	int   hold_bit = -1;
	logic idle_hi = 1'b0;
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
		hold_n_o = 1'b1;
		oe_seen_o = 1'b0;
	end
	// released line shows inverse of its last level, so stale data never passes
	always @(posedge clk_i) begin
		if (so_oe_i) last_q <= so_i;
		if (so_oe_i) oe_seen_o <= 1'b1;
	end
	assign so_w_o = so_oe_i ? so_i : ~last_q;
	task automatic half();
		repeat (10) @(negedge clk_i);
	endtask
	task automatic sel();
		oe_seen_o = 1'b0;
		cs_n_o = 1'b0;
		half();
	endtask
	task automatic desel();
		half();
		cs_n_o = 1'b1;
		half();
	endtask
	// hold moves only while sck is low
	task automatic pause();
		hold_n_o = 1'b0;
		repeat (40) @(negedge clk_i);
		hold_n_o = 1'b1;
	endtask
	// idle level of sck picks mode 0 or mode 3; only while deselected
	task automatic set_mode(input logic hi);
		idle_hi = hi;
		sck_o = hi;
		half();
	endtask
	// bits go msb first, sampled on the sck rise; mode 3 opens each bit with a fall
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			if (idle_hi) sck_o = 1'b0;
			si_o = tx[i];
			if (i == hold_bit) pause();
			half();
			sck_o = 1'b1;
			rx[i] = so_w_o;
			half();
			if (!idle_hi) sck_o = 1'b0;
		end
	endtask
endmodule

/* File: snr_spi_nvram_tb.sv */
// self-checking bench of the spi nvram read, sleep and ident block
module snr_spi_nvram_tb;
	import snr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cs_n, sck, si, hold_n, so, so_oe, so_w, oe_seen, asleep;
	logic [14:0] mem_addr;
	logic [7:0]  rx;
	int          bad_count = 0;
	int          check_count = 0;
	function automatic logic [7:0] md(input logic [14:0] a);
		return a[7:0] + {1'b0, a[14:8]};
	endfunction
	always #2 clk_i = ~clk_i;
	snr_spi_nvram #(.WAKE_CYC(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
		.hold_n_i(hold_n), .so_o(so), .so_oe_o(so_oe), .mem_addr_o(mem_addr), .mem_data_i(md(mem_addr)),
		.asleep_o(asleep));
	snr_spi_master m (.clk_i(clk_i), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
		.hold_n_o(hold_n), .so_w_o(so_w), .oe_seen_o(oe_seen));
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// header msb set and start near the top to force the wrap
	task automatic t_fast_read();
		m.sel();
		m.xfer(SNR_OP_FAST_READ, rx);
		m.xfer(8'hff, rx);
		m.xfer(8'hfe, rx);
		chk("header quiet", {7'h0, oe_seen}, 8'h0);
		m.xfer(8'h00, rx);
		for (int i = 0; i < 3; i++) begin
			m.xfer(8'h55 << i, rx);
			chk("read data", rx, md(15'h7ffe + 15'(i)));
		end
		m.desel();
		chk("so released", {7'h0, so_oe}, 8'h0);
	endtask
	task automatic t_hold();
		m.sel();
		m.xfer(SNR_OP_FAST_READ, rx);
		m.xfer(8'h00, rx);
		m.xfer(8'h10, rx);
		m.xfer(8'h00, rx);
		m.hold_bit = 4;
		m.xfer(8'h00, rx);
		chk("held byte", rx, md(15'h0010));
		m.hold_bit = -1;
		m.xfer(8'h00, rx);
		chk("after hold", rx, md(15'h0011));
		m.desel();
	endtask
	task automatic t_ident();
		logic [7:0] e;
		m.sel();
		m.xfer(SNR_OP_READ_IDENT, rx);
		for (int i = 0; i < 9; i++) begin
			e = i < 6 ? SNR_ID_CONT : i == 6 ? SNR_ID_MFR : i == 7 ? {SNR_ID_FAMILY, SNR_ID_DENS}
				: {SNR_ID_SUB, SNR_ID_REV, SNR_ID_RSVD};
			m.xfer(8'h00, rx);
			chk("ident byte", rx, e);
		end
		m.desel();
	endtask
	task automatic t_unknown();
		m.sel();
		m.xfer(8'h5e, rx);
		m.xfer(8'h00, rx);
		m.xfer(8'h00, rx);
		m.desel();
		chk("unknown quiet", {7'h0, oe_seen}, 8'h0);
	endtask
	// wake frame is thrown away; a real command follows later
	task automatic t_sleep();
		m.sel();
		m.xfer(SNR_OP_SLEEP, rx);
		m.desel();
		chk("asleep", {7'h0, asleep}, 8'h1);
		m.xfer(SNR_OP_READ_IDENT, rx);
		m.sel();
		for (int i = 0; i < 5; i++) m.xfer(SNR_OP_READ_IDENT, rx);
		m.desel();
		chk("wake quiet", {7'h0, oe_seen}, 8'h0);
		chk("awake", {7'h0, asleep}, 8'h0);
	endtask
	// main sequence after eight cycles of reset
	initial begin
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (4) @(negedge clk_i);
		t_fast_read();
		t_hold();
		t_ident();
		t_unknown();
		t_sleep();
		t_ident();
		m.set_mode(1'b1);
		t_fast_read();
		t_ident();
		give_verdict();
	end
	// run needs about 40 us; a hang is cut well beyond that
	initial begin
		#200000;
		bad_count++;
		give_verdict();
	end
endmodule
bind snr_spi_nvram snr_spi_nvram_asserts #(.ADDR_W(ADDR_W), .WAKE_CYC(WAKE_CYC)) chk_u (.clk_i(clk_i),
	.rst_i(rst_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .hold_n_i(hold_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
	.mem_addr_o(mem_addr_o), .asleep_o(asleep_o));
